// ===== logic/jrad_pkg.sv
// Shared constants for the jrad block.
package jrad_pkg;
    // Identifier field layout of a 29-bit frame identifier.
    localparam int ID_W = 29;
    localparam int ID_PRIO_LSB = 26;
    localparam int ID_DP_BIT = 24;
    localparam int ID_PF_LSB = 16;
    localparam int ID_PS_LSB = 8;
    localparam logic [2:0] DEFAULT_PRIO = 3'h6;

    // Parameter group numbers and PDU fields.
    localparam logic [23:0] REQ_PGN = 24'h00_EA00;
    localparam logic [7:0] REQ_PF = 8'hEA;
    localparam logic [3:0] REQ_DLC = 4'h3;
    localparam logic [23:0] ACK_PGN = 24'h00_E800;
    localparam logic [7:0] ACK_PF = 8'hE8;
    localparam logic [23:0] SOFT_PGN = 24'h00_FEDA;
    localparam logic [7:0] SOFT_PF = 8'hFE;
    localparam logic [7:0] SOFT_PS = 8'hDA;
    localparam logic [3:0] FULL_DLC = 4'h8;
    localparam logic [7:0] PDU2_MIN_PF = 8'hF0;

    // Acknowledgement data bytes.
    localparam logic [7:0] ACK_POSITIVE = 8'h00;
    localparam logic [7:0] ACK_NEGATIVE = 8'h01;
    localparam logic [7:0] ACK_UNUSED = 8'hFF;

    // Software identification payload framing.
    localparam logic [7:0] SOFT_FIELD_COUNT = 8'h01;
    localparam logic [7:0] SOFT_DELIMITER = 8'h2A;

    // Data substitution codes.
    localparam logic [15:0] POS_ERROR_WORD = 16'hFEFF;
    localparam logic [7:0] TEMP_ERROR_BYTE = 8'hFE;

    // Operation status codes, ordered by severity so the worst one wins.
    localparam logic [2:0] OP_NORMAL = 3'h0;
    localparam logic [2:0] OP_ALARM = 3'h1;
    localparam logic [2:0] OP_ALARM_HIGH = 3'h2;
    localparam logic [2:0] OP_DERATE = 3'h3;
    localparam logic [2:0] OP_CTRL_SD = 3'h4;

    // Temperature status codes, ordered by severity.
    localparam logic [2:0] TS_IN_RANGE = 3'h0;
    localparam logic [2:0] TS_LOW_LEAST = 3'h1;
    localparam logic [2:0] TS_HIGH_LEAST = 3'h2;
    localparam logic [2:0] TS_HIGH_MOST = 3'h3;
    localparam logic [2:0] TS_ERROR = 3'h4;
    localparam logic [4:0] FMI_NORMAL = 5'h1F;

    // Diagnostic conditions: 0 zero drive, 1 demand loss, 2 position error,
    // 3 temperature derate, 4 sensor failed, 5 demand out of range, 6 temperature low.
    localparam int DIAG_N = 7;
    localparam int LEG_W = 16;
    localparam int NEW_W = 32;
    localparam int DIAG_LEG_EN [DIAG_N] = '{1, 0, 1, 0, 0, 1, 1};
    localparam int DIAG_LEG_POS [DIAG_N] = '{6, 0, 8, 0, 0, 12, 7};
    localparam int DIAG_NEW_EN [DIAG_N] = '{1, 1, 1, 1, 1, 1, 0};
    localparam int DIAG_NEW_POS [DIAG_N] = '{14, 20, 6, 12, 10, 26, 0};
    localparam int DIAG_FMI_EN [DIAG_N] = '{1, 1, 1, 1, 1, 1, 0};
    localparam int DIAG_FMI [DIAG_N] = '{0, 14, 7, 15, 12, 16, 0};
    localparam int DIAG_OP_ALARM [DIAG_N] = '{4, 2, 2, 3, 3, 1, 1};
    localparam int DIAG_OP_SD [DIAG_N] = '{4, 4, 4, 4, 3, 4, 4};
    localparam int DIAG_TEMP [DIAG_N] = '{3, 0, 0, 2, 4, 0, 1};
    localparam int DIAG_LOSS_DEMAND = 1;
    localparam int DIAG_SENSOR_FAIL = 4;

    // Register map, byte addresses of 32-bit words.
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ACTION = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_LEGACY = 8'h0C;
    localparam logic [7:0] REG_NEWBITS = 8'h10;
    localparam logic [7:0] REG_LAST_REQ = 8'h14;
    localparam int CTRL_EN_BIT = 8;
    localparam logic [7:0] RESET_ADDR = 8'h00;
    localparam logic [6:0] RESET_ACTION = 7'h00;
    localparam int STATUS_OP_LSB = 8;
    localparam int STATUS_TEMP_LSB = 12;
    localparam int STATUS_BUSY_BIT = 16;
endpackage

// ===== logic/jrad_diag_entry.sv
// One diagnostic condition mapped onto its reporting fields.
`timescale 1ns/1ps
`default_nettype none
module jrad_diag_entry
    import jrad_pkg::*;
#(
    parameter int LEG_EN = 0,
    parameter int LEG_POS = 0,
    parameter int NEW_EN = 0,
    parameter int NEW_POS = 0,
    parameter int FMI_EN = 0,
    parameter int FMI = 0,
    parameter int OP_ALARM = 0,
    parameter int OP_SD = 0,
    parameter int TEMP = 0
) (
    input wire logic active, // Condition present.
    input wire logic shutdown_action, // High when configured as a shutdown.
    output logic [LEG_W-1:0] legacy_vec, // Legacy bit contribution.
    output logic [NEW_W-1:0] new_vec, // New bit contribution.
    output logic fmi_hit, // This condition offers an indicator.
    output logic [4:0] fmi, // Failure mode indicator value.
    output logic [2:0] op, // Operation status contribution.
    output logic [2:0] temp // Temperature status contribution.
);
    if (LEG_POS >= LEG_W || NEW_POS >= NEW_W || FMI > 31) begin : g_bad
        $error("Diagnostic entry field out of range.");
    end

    localparam logic [LEG_W-1:0] LEG_MASK = (LEG_EN != 0) ? (LEG_W'(1) << LEG_POS) : '0;
    localparam logic [NEW_W-1:0] NEW_MASK = (NEW_EN != 0) ? (NEW_W'(1) << NEW_POS) : '0;

    // Inactive conditions give zero bit vectors, so merging those is a plain OR.
    assign legacy_vec = active ? LEG_MASK : '0;
    assign new_vec = active ? NEW_MASK : '0;
    assign fmi_hit = active && (FMI_EN != 0);
    assign fmi = 5'(FMI);
    assign op = !active ? OP_NORMAL : (shutdown_action ? 3'(OP_SD) : 3'(OP_ALARM));
    assign temp = active ? 3'(TEMP) : TS_IN_RANGE;
endmodule
`default_nettype wire

// ===== logic/jrad_map.sv
// Group requests, acknowledgements and diagnostic field mapping.
`timescale 1ns/1ps
`default_nettype none
module jrad_map
    import jrad_pkg::*;
#(
    parameter logic [47:0] SOFT_ID = 48'h3030_322E_3030, // Six identification characters.
    parameter logic [23:0] DM3_PGN = 24'h00_FECC, // Group that clears stored codes.
    parameter logic [23:0] DM11_PGN = 24'h00_FED3, // Group that clears active codes.
    parameter int CLEAR_WAIT_MAX = 255 // Cycles allowed for a clear to finish.
) (
    input wire logic mclk, // System clock, 125 MHz.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic ce, // Clock enable; all state holds while low.
    input wire logic [ADDR_W-1:0] bus_addr, // Register byte address.
    input wire logic [31:0] bus_wdata, // Register write data.
    input wire logic bus_wr, // Register write strobe.
    input wire logic bus_rd, // Register read strobe.
    output logic [31:0] bus_rdata, // Read data, valid the cycle after bus_rd.
    input wire logic rx_valid, // Received frame pulse from the controller.
    input wire logic [ID_W-1:0] rx_id, // Received 29-bit identifier.
    input wire logic [3:0] rx_dlc, // Received data length.
    input wire logic [63:0] rx_data, // Received data, byte one in bits 7:0.
    output logic tx_valid, // Frame waiting for transmission.
    input wire logic tx_ready, // Controller takes the frame.
    output logic [ID_W-1:0] tx_id, // Transmit identifier.
    output logic [3:0] tx_dlc, // Transmit data length.
    output logic [63:0] tx_data, // Transmit data, byte one in bits 7:0.
    output logic clear_dm3, // One-cycle pulse: clear stored codes.
    output logic clear_dm11, // One-cycle pulse: clear active codes.
    input wire logic clear_done, // Fault logic finished the clear.
    input wire logic clear_ok, // Clear succeeded, read with clear_done.
    input wire logic [DIAG_N-1:0] diag_active, // Diagnostic conditions present.
    input wire logic [15:0] desired_pos_in, // Desired position in use.
    input wire logic [15:0] feedback_pos_in, // Actual feedback position.
    input wire logic [7:0] temp_in, // Electronics temperature.
    output logic [LEG_W-1:0] legacy_bits, // Legacy bit field, bytes 5 and 6.
    output logic [NEW_W-1:0] new_bits, // New bit field, bytes 1 to 4.
    output logic [4:0] fmi_out, // Preliminary failure mode indicator.
    output logic [2:0] op_status, // Operation status code.
    output logic [2:0] temp_status, // Temperature status code.
    output logic [15:0] desired_pos_out, // Reported desired position.
    output logic [15:0] feedback_pos_out, // Reported feedback position.
    output logic [7:0] temp_out // Reported temperature.
);
    if (DM3_PGN == DM11_PGN || DM3_PGN == SOFT_PGN || DM11_PGN == SOFT_PGN ||
        CLEAR_WAIT_MAX < 1 || CLEAR_WAIT_MAX > 255) begin : g_bad
        $error("Clear groups must differ and the clear wait must fit eight bits.");
    end

    localparam logic [7:0] CLEAR_WAIT = 8'(CLEAR_WAIT_MAX);

    typedef enum {JRAD_IDLE, JRAD_CLEAR, JRAD_SEND} jrad_state_t;

    jrad_state_t state;
    jrad_state_t next_state;
    logic [7:0] own_addr;
    logic node_en;
    logic [DIAG_N-1:0] shutdown_action;
    logic [23:0] last_req;
    logic [7:0] peer_addr;
    logic [23:0] pend_pgn;
    logic [7:0] wait_cnt;

    // Fields of the received identifier.
    wire [7:0] rx_pf = rx_id[ID_PF_LSB +: 8];
    wire [7:0] rx_ps = rx_id[ID_PS_LSB +: 8];
    wire [7:0] rx_sa = rx_id[7:0];
    wire rx_dp = rx_id[ID_DP_BIT];
    // Byte one is the least significant byte of the requested group.
    wire [23:0] req_pgn = rx_data[23:0];
    // Only a request addressed to this node with at least three bytes is a request.
    wire is_req = rx_valid && node_en && !rx_dp && rx_pf == REQ_PF &&
        rx_ps == own_addr && rx_dlc >= REQ_DLC;
    // A request arriving while a reply is still pending is dropped.
    wire take_req = is_req && state == JRAD_IDLE;
    // Requesters zero the low byte of PDU1 groups, so whole numbers compare.
    wire want_soft = req_pgn == SOFT_PGN;
    wire want_dm3 = req_pgn == DM3_PGN;
    wire want_dm11 = req_pgn == DM11_PGN;
    wire want_clear = want_dm3 || want_dm11;
    wire clear_timeout = wait_cnt == CLEAR_WAIT;
    wire tx_taken = tx_valid && tx_ready;

    // Identifier builders for the two frames this node sends.
    wire [ID_W-1:0] ack_id = {DEFAULT_PRIO, 2'b00, ACK_PF, rx_sa, own_addr};
    wire [ID_W-1:0] ack_id_pend = {DEFAULT_PRIO, 2'b00, ACK_PF, peer_addr, own_addr};
    wire [ID_W-1:0] soft_id_hdr = {DEFAULT_PRIO, 2'b00, SOFT_PF, SOFT_PS, own_addr};

    // Identification reply: count byte, characters first-to-last, delimiter.
    wire [63:0] soft_payload = {SOFT_DELIMITER, SOFT_ID[7:0], SOFT_ID[15:8],
        SOFT_ID[23:16], SOFT_ID[31:24], SOFT_ID[39:32], SOFT_ID[47:40], SOFT_FIELD_COUNT};

    // Acknowledge payload: control, three unused bytes, address, group low first.
    function automatic logic [63:0] ack_payload(input logic [7:0] ctrl,
                                                input logic [7:0] addr,
                                                input logic [23:0] pgn);
        ack_payload = {pgn, addr, ACK_UNUSED, ACK_UNUSED, ACK_UNUSED, ctrl};
    endfunction

    // Clear outcome for the pending acknowledge; a timeout counts as failure.
    wire [7:0] clear_ctrl = (clear_done && clear_ok) ? ACK_POSITIVE : ACK_NEGATIVE;

    // Next state of the request sequencer.
    always_comb begin
        next_state = state;
        case (state)
            JRAD_IDLE: begin
                if (take_req) begin
                    next_state = want_clear ? JRAD_CLEAR : JRAD_SEND;
                end
            end
            JRAD_CLEAR: begin
                if (clear_done || clear_timeout) begin
                    next_state = JRAD_SEND;
                end
            end
            JRAD_SEND: begin
                if (tx_taken) begin
                    next_state = JRAD_IDLE;
                end
            end
            default: begin
                next_state = JRAD_IDLE;
            end
        endcase
    end

    // Sequencer state and request bookkeeping.
    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= JRAD_IDLE;
            peer_addr <= 8'h00;
            pend_pgn <= 24'h00_0000;
            last_req <= 24'h00_0000;
            wait_cnt <= 8'h00;
        end else if (ce) begin
            state <= next_state;
            if (take_req) begin
                peer_addr <= rx_sa;
                pend_pgn <= req_pgn;
                last_req <= req_pgn;
            end
            wait_cnt <= (state == JRAD_CLEAR) ? wait_cnt + 8'h01 : 8'h00;
        end
    end

    // Clear triggers last one cycle, issued as the request is taken.
    always_ff @(posedge mclk) begin
        if (srst) begin
            clear_dm3 <= 1'b0;
            clear_dm11 <= 1'b0;
        end else if (ce) begin
            clear_dm3 <= take_req && want_dm3;
            clear_dm11 <= take_req && want_dm11;
        end
    end

    // Transmit frame, held until the controller takes it.
    always_ff @(posedge mclk) begin
        if (srst) begin
            tx_valid <= 1'b0;
            tx_id <= '0;
            tx_dlc <= 4'h0;
            tx_data <= 64'h0000_0000_0000_0000;
        end else if (ce) begin
            if (tx_taken) begin
                tx_valid <= 1'b0;
            end
            if (take_req && want_soft) begin
                tx_valid <= 1'b1;
                tx_id <= soft_id_hdr;
                tx_dlc <= FULL_DLC;
                tx_data <= soft_payload;
            end else if (take_req && !want_clear) begin
                // Any other group is not available here and is refused.
                tx_valid <= 1'b1;
                tx_id <= ack_id;
                tx_dlc <= FULL_DLC;
                tx_data <= ack_payload(ACK_NEGATIVE, rx_sa, req_pgn);
            end else if (state == JRAD_CLEAR && (clear_done || clear_timeout)) begin
                tx_valid <= 1'b1;
                tx_id <= ack_id_pend;
                tx_dlc <= FULL_DLC;
                tx_data <= ack_payload(clear_ctrl, peer_addr, pend_pgn);
            end
        end
    end

    // Per-condition contributions, merged below.
    logic [LEG_W-1:0] leg_part [DIAG_N];
    logic [NEW_W-1:0] new_part [DIAG_N];
    logic [DIAG_N-1:0] fmi_hit;
    logic [4:0] fmi_part [DIAG_N];
    logic [2:0] op_part [DIAG_N];
    logic [2:0] temp_part [DIAG_N];

    for (genvar g = 0; g < DIAG_N; g++) begin : g_diag
        // Field positions and codes per condition.
        jrad_diag_entry #(
            .LEG_EN(DIAG_LEG_EN[g]),
            .LEG_POS(DIAG_LEG_POS[g]),
            .NEW_EN(DIAG_NEW_EN[g]),
            .NEW_POS(DIAG_NEW_POS[g]),
            .FMI_EN(DIAG_FMI_EN[g]),
            .FMI(DIAG_FMI[g]),
            .OP_ALARM(DIAG_OP_ALARM[g]),
            .OP_SD(DIAG_OP_SD[g]),
            .TEMP(DIAG_TEMP[g])
        ) u_entry (
            .active(diag_active[g]),
            .shutdown_action(shutdown_action[g]),
            .legacy_vec(leg_part[g]),
            .new_vec(new_part[g]),
            .fmi_hit(fmi_hit[g]),
            .fmi(fmi_part[g]),
            .op(op_part[g]),
            .temp(temp_part[g])
        );
    end

    // Bits are ORed; the lowest-numbered condition gives the indicator, and
    // status codes take the worst value so a milder fault cannot mask a shutdown.
    logic [LEG_W-1:0] next_legacy;
    logic [NEW_W-1:0] next_new;
    logic [4:0] next_fmi;
    logic [2:0] next_op;
    logic [2:0] next_temp;
    always_comb begin
        next_legacy = '0;
        next_new = '0;
        next_fmi = FMI_NORMAL;
        next_op = OP_NORMAL;
        next_temp = TS_IN_RANGE;
        for (int i = DIAG_N - 1; i >= 0; i--) begin
            next_legacy = next_legacy | leg_part[i];
            next_new = next_new | new_part[i];
            if (fmi_hit[i]) begin
                next_fmi = fmi_part[i];
            end
            if (op_part[i] > next_op) begin
                next_op = op_part[i];
            end
            if (temp_part[i] > next_temp) begin
                next_temp = temp_part[i];
            end
        end
    end

    // Reported data words with substitution codes.
    wire [15:0] next_desired = diag_active[DIAG_LOSS_DEMAND] ? POS_ERROR_WORD :
        desired_pos_in;
    wire [7:0] next_temp_data = diag_active[DIAG_SENSOR_FAIL] ? TEMP_ERROR_BYTE :
        temp_in;

    // Registered so the frame builder sees stable values.
    always_ff @(posedge mclk) begin
        if (srst) begin
            legacy_bits <= '0;
            new_bits <= '0;
            fmi_out <= FMI_NORMAL;
            op_status <= OP_NORMAL;
            temp_status <= TS_IN_RANGE;
            desired_pos_out <= 16'h0000;
            feedback_pos_out <= 16'h0000;
            temp_out <= 8'h00;
        end else if (ce) begin
            legacy_bits <= next_legacy;
            new_bits <= next_new;
            fmi_out <= next_fmi;
            op_status <= next_op;
            temp_status <= next_temp;
            desired_pos_out <= next_desired;
            feedback_pos_out <= feedback_pos_in;
            temp_out <= next_temp_data;
        end
    end

    // Register writes: address, enable, shutdown settings.
    wire wr_ctrl = bus_wr && bus_addr == REG_CTRL;
    wire wr_action = bus_wr && bus_addr == REG_ACTION;
    always_ff @(posedge mclk) begin
        if (srst) begin
            own_addr <= RESET_ADDR;
            node_en <= 1'b0;
            shutdown_action <= RESET_ACTION;
        end else if (ce) begin
            if (wr_ctrl) begin
                own_addr <= bus_wdata[7:0];
                node_en <= bus_wdata[CTRL_EN_BIT];
            end
            if (wr_action) begin
                shutdown_action <= bus_wdata[DIAG_N-1:0];
            end
        end
    end

    // Read multiplexer; unmapped addresses read as zero.
    wire [31:0] status_word = {15'h0000, state != JRAD_IDLE, 1'b0, op_status,
        1'b0, temp_status, 3'h0, fmi_out};
    wire [31:0] rd_mux = (bus_addr == REG_CTRL) ? {23'h00_0000, node_en, own_addr} :
        (bus_addr == REG_ACTION) ? {25'h000_0000, shutdown_action} :
        (bus_addr == REG_STATUS) ? status_word :
        (bus_addr == REG_LEGACY) ? {16'h0000, legacy_bits} :
        (bus_addr == REG_NEWBITS) ? new_bits :
        (bus_addr == REG_LAST_REQ) ? {8'h00, last_req} : 32'h0000_0000;

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge mclk) begin
        if (srst) begin
            bus_rdata <= 32'h0000_0000;
        end else if (ce) begin
            bus_rdata <= bus_rd ? rd_mux : 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// ===== test/jrad_map_assertions.sv
// Port checks for jrad_map.
`timescale 1ns/1ps
`default_nettype none
module jrad_map_assertions
    import jrad_pkg::*;
(
    input wire logic mclk, // Clock.
    input wire logic srst, // Reset.
    input wire logic ce, // Clock enable.
    input wire logic tx_valid, // Frame offered.
    input wire logic tx_ready, // Frame taken.
    input wire logic [ID_W-1:0] tx_id, // Frame identifier.
    input wire logic [3:0] tx_dlc, // Frame length.
    input wire logic [63:0] tx_data, // Frame data.
    input wire logic [DIAG_N-1:0] diag_active, // Conditions present.
    input wire logic [4:0] fmi_out, // Indicator.
    input wire logic [2:0] op_status, // Operation status.
    input wire logic [2:0] temp_status, // Temperature status.
    input wire logic [NEW_W-1:0] new_bits, // New bit field.
    input wire logic [7:0] temp_out // Reported temperature.
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // Frames are told apart by their PDU format field alone.
    wire logic is_ack = tx_valid && tx_id[23:16] == ACK_PF;
    wire logic is_soft = tx_valid && tx_id[23:16] == SOFT_PF;
    a_ack_header: assert property (is_ack |-> tx_dlc == FULL_DLC && tx_id[28:24] == 5'h18)
        else $error("ack header wrong");
    a_ack_control: assert property (is_ack |-> tx_data[7:1] == 7'h00)
        else $error("ack control");
    a_ack_unused: assert property (is_ack |-> tx_data[31:8] == 24'hFF_FFFF)
        else $error("ack unused");
    a_ack_echo: assert property (is_ack |-> tx_data[39:32] == tx_id[15:8])
        else $error("ack address");
    a_soft_frame: assert property (is_soft |-> tx_data[7:0] == 8'h01
        && tx_data[63:56] == 8'h2A && tx_id[15:8] == SOFT_PS) else $error("soft frame");
    a_tx_holds: assert property (tx_valid && !tx_ready && ce |=> tx_valid && $stable(tx_data))
        else $error("frame not held");
    a_zero_drive: assert property (ce && diag_active[0] && !diag_active[4] |=>
        op_status == OP_CTRL_SD && temp_status == TS_HIGH_MOST && new_bits[14]) else $error("zero drive");
    a_sensor_fail: assert property (ce && diag_active[4] |=>
        temp_out == 8'hFE && temp_status == TS_ERROR) else $error("sensor report");
    a_pos_error: assert property (ce && diag_active == 7'h04 |=>
        fmi_out == 5'h07 && new_bits[6]) else $error("position report");
    c_ack: cover property (is_ack && tx_ready);
    c_soft: cover property (is_soft && tx_ready);
    c_all_diag: cover property (diag_active == 7'h7F);
endmodule
bind jrad_map jrad_map_assertions u_chk (.mclk(mclk), .srst(srst), .ce(ce),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id), .tx_dlc(tx_dlc),
    .tx_data(tx_data), .diag_active(diag_active), .fmi_out(fmi_out), .op_status(op_status),
    .temp_status(temp_status), .new_bits(new_bits), .temp_out(temp_out));
`default_nettype wire

// ===== test/jrad_far_end.sv
// Requesting node model.
`timescale 1ns/1ps
`default_nettype none
module jrad_far_end
    import jrad_pkg::*;
(
    input wire logic mclk, // Clock.
    input wire logic slow, // Random stalls.
    output logic rx_valid = 1'b0, // Frame pulse.
    output logic [ID_W-1:0] rx_id = '0, // Frame identifier.
    output logic [3:0] rx_dlc = 4'h0, // Frame length.
    output logic [63:0] rx_data = '0, // Frame data.
    output logic tx_ready = 1'b0 // Frame accepted.
);
    // A slow node refuses about two frames in three, so holding is exercised.
    always @(posedge mclk) begin
        tx_ready <= slow ? ($urandom_range(2) == 0) : 1'b1;
    end
    // One request, then inverted lines so stale data never match.
    task automatic request(input logic [7:0] dst, input logic [7:0] src, input logic [23:0] pgn);
        logic [23:0] want;
        want = pgn;
        if (pgn[15:8] < PDU2_MIN_PF) want[7:0] = 8'h00;
        @(posedge mclk);
        rx_valid <= 1'b1;
        rx_id <= {DEFAULT_PRIO, 2'b00, REQ_PF, dst, src};
        rx_dlc <= REQ_DLC;
        rx_data <= {40'hA5_5A5A_A55A, want};
        @(posedge mclk);
        rx_valid <= 1'b0;
        rx_id <= ~rx_id;
        rx_data <= ~rx_data;
    endtask
endmodule
`default_nettype wire

// ===== test/jrad_map_tb.sv
// Self-checking bench for jrad_map.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module jrad_map_tb
    import jrad_pkg::*;
;
    localparam logic [23:0] DM3 = 24'h00_FECC;
    localparam logic [23:0] DM11 = 24'h00_FED3;
    logic mclk = 1'b0, srst = 1'b1, ce = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, slow = 1'b0;
    logic clear_done = 1'b0, clear_ok = 1'b0, answer = 1'b1, ok = 1'b1;
    logic [7:0] bus_addr = 8'h00, own = 8'h00, sa, temp_in = 8'h50, temp_out;
    logic [31:0] bus_wdata = 32'h0000_0000, bus_rdata;
    logic [DIAG_N-1:0] diag_active = '0, act;
    logic [15:0] desired_pos_in = 16'h1234, feedback_pos_in = 16'h4321;
    logic [15:0] legacy_bits, desired_pos_out, feedback_pos_out;
    logic rx_valid, tx_valid, tx_ready, clear_dm3, clear_dm11;
    logic [ID_W-1:0] rx_id, tx_id;
    logic [3:0] rx_dlc, tx_dlc;
    logic [63:0] rx_data, tx_data;
    logic [NEW_W-1:0] new_bits;
    logic [4:0] fmi_out;
    logic [2:0] op_status, temp_status;
    logic [23:0] p;
    int bad_count = 0, n_tests = 0, n3 = 0, n11 = 0;
    // Expected per condition; -1 means no bit.
    int leg_e [DIAG_N] = '{6, -1, 8, -1, -1, 12, 7};
    int new_e [DIAG_N] = '{14, 20, 6, 12, 10, 26, -1};
    int fmi_e [DIAG_N] = '{0, 14, 7, 15, 12, 16, 31};

    jrad_map #(.DM3_PGN(DM3), .DM11_PGN(DM11), .CLEAR_WAIT_MAX(4)) u_jrad_map (
        .mclk(mclk), .srst(srst), .ce(ce), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .rx_valid(rx_valid),
        .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data),
        .clear_dm3(clear_dm3), .clear_dm11(clear_dm11), .clear_done(clear_done),
        .clear_ok(clear_ok), .diag_active(diag_active), .desired_pos_in(desired_pos_in),
        .feedback_pos_in(feedback_pos_in), .temp_in(temp_in), .legacy_bits(legacy_bits),
        .new_bits(new_bits), .fmi_out(fmi_out), .op_status(op_status),
        .temp_status(temp_status), .desired_pos_out(desired_pos_out),
        .feedback_pos_out(feedback_pos_out), .temp_out(temp_out));
    jrad_far_end u_far (.mclk(mclk), .slow(slow), .rx_valid(rx_valid), .rx_id(rx_id),
        .rx_dlc(rx_dlc), .rx_data(rx_data), .tx_ready(tx_ready));

    initial begin
        forever #4 mclk = ~mclk;
    end
    // Fault logic stand-in: answers a clear one cycle later.
    always @(posedge mclk) begin
        clear_done <= answer && (clear_dm3 || clear_dm11);
        clear_ok <= ok;
        n3 <= n3 + int'(clear_dm3);
        n11 <= n11 + int'(clear_dm11);
    end
    function automatic logic [31:0] bit_at(input int b);
        return b < 0 ? 32'h0000_0000 : 32'h0000_0001 << b;
    endfunction
    function automatic logic [ID_W-1:0] idof(input logic [7:0] pf, input logic [7:0] ps);
        return {DEFAULT_PRIO, 2'b00, pf, ps, own};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge mclk);
        bus_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge mclk);
        bus_rd <= 1'b0;
        #1 `CHK(bus_rdata, e)
    endtask
    // Bounded wait for the handshake, then frame compare.
    task automatic tx_chk(input logic [ID_W-1:0] id, input logic [63:0] d);
        #1;
        for (int i = 0; i < 400 && !(tx_valid === 1'b1 && tx_ready === 1'b1); i++) begin
            @(posedge mclk);
            #1;
        end
        `CHK(tx_id, id)
        `CHK({tx_dlc, tx_data}, {FULL_DLC, d})
        @(posedge mclk);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge mclk);
        bad_count++;
        stop_test();
    end
    initial begin
        void'($urandom(34697));
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        rdc(REG_CTRL, 32'h0000_0000);
        own = 8'($urandom_range(254));
        wr(REG_CTRL, 32'h0000_0100 | 32'(own));
        rdc(REG_CTRL, 32'h0000_0100 | 32'(own));
        rdc(8'h3C, 32'h0000_0000);
        sa = 8'($urandom);
        u_far.request(own ^ 8'h01, sa, SOFT_PGN);
        u_far.request(own, sa, SOFT_PGN);
        tx_chk(idof(SOFT_PF, SOFT_PS), 64'h2A30_302E_3230_3001);
        slow <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            p = (k == 0) ? 24'h00_FEDB : {8'h00, 8'($urandom_range(239)), 8'h00};
            sa = 8'($urandom);
            u_far.request(own, sa, p);
            tx_chk(idof(ACK_PF, sa), {p, sa, 24'hFF_FFFF, 8'h01});
        end
        rdc(REG_LAST_REQ, {8'h00, p});
        // Clear succeeds, is refused, is never answered.
        for (int k = 0; k < 3; k++) begin
            ok <= (k == 0);
            answer <= (k < 2);
            p = k[0] ? DM3 : DM11;
            u_far.request(own, sa, p);
            tx_chk(idof(ACK_PF, sa), {p, sa, 24'hFF_FFFF, 7'h00, k != 0});
        end
        `CHK({n11, n3}, {32'd2, 32'd1})
        for (int i = 0; i < DIAG_N; i++) begin
            act = 7'($urandom);
            wr(REG_ACTION, 32'(act));
            diag_active <= 7'h01 << i;
            desired_pos_in <= 16'($urandom);
            feedback_pos_in <= 16'($urandom);
            temp_in <= 8'($urandom);
            repeat (2) @(posedge mclk);
            #1 `CHK(fmi_out, 5'(fmi_e[i]))
            `CHK(op_status, 3'(act[i] ? DIAG_OP_SD[i] : DIAG_OP_ALARM[i]))
            `CHK(temp_status, 3'(DIAG_TEMP[i]))
            `CHK({new_bits, legacy_bits}, {bit_at(new_e[i]), 16'(bit_at(leg_e[i]))})
            `CHK(desired_pos_out, i == 1 ? 16'hFEFF : desired_pos_in)
            `CHK({temp_out, feedback_pos_out}, {i == 4 ? 8'hFE : temp_in, feedback_pos_in})
        end
        diag_active <= 7'h7F;
        repeat (2) @(posedge mclk);
        #1 `CHK({fmi_out, op_status, temp_status}, {5'h00, OP_CTRL_SD, TS_ERROR})
        stop_test();
    end
endmodule
`default_nettype wire
